// >>> src/dhb_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhb_params.svh"
module dhb_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic bridge_a_ctrl_first,
   input wire logic bridge_a_ctrl_first_undriven,
   input wire logic bridge_a_ctrl_second,
   input wire logic bridge_a_ctrl_second_undriven,
   input wire logic bridge_b_ctrl_first,
   input wire logic bridge_b_ctrl_second,
   input wire logic sleep_request_low,
   input wire logic supply_undervoltage_lockout,
   input wire logic thermal_shutdown,
   input wire logic [1:0] sense_trip,
   input wire logic [1:0] current_near_zero,
   input wire logic [1:0] oc_high_side,
   input wire logic [1:0] oc_low_side,
   output logic [1:0] bridge_a_drive_first,
   output logic [1:0] bridge_a_drive_second,
   output logic [1:0] bridge_b_drive_first,
   output logic [1:0] bridge_b_drive_second,
   output logic internal_regulator_output,
   output logic fault_indicator_low,
   output logic parallel_mode
);
   // undervoltage resets sequencing, mode and bridges; the axi slave, chop_en and the fault output reset on aresetn only
   wire logic rst_n = aresetn & ~supply_undervoltage_lockout;
   dhb_pkg::dhb_pwr_t pw;
   logic [`DHB_CNT_W-1:0] pw_cnt;
   logic sleep_d;
   logic run;
   logic chop_en;
   logic [1:0] oc_fault;
   logic [1:0] a_first;
   logic [1:0] a_second;
   logic [1:0] b_first;
   logic [1:0] b_second;
   logic aw_got;
   logic w_got;
   logic [31:0] aw_addr;
   logic [31:0] wd;

   ////////////////////////////////////////////////////////////////
   // power sequencing: wake delay, sleep delay
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         pw <= dhb_pkg::DHB_PW_WAKE;
         pw_cnt <= '0;
      end else begin
         case (pw)
            dhb_pkg::DHB_PW_SLEEP: begin
               pw_cnt <= '0;
               if (sleep_request_low) pw <= dhb_pkg::DHB_PW_WAKE;
            end
            dhb_pkg::DHB_PW_WAKE: begin
               if (!sleep_request_low) begin
                  pw <= dhb_pkg::DHB_PW_SLEEP;
                  pw_cnt <= '0;
               end else if (pw_cnt == `DHB_CNT_W'(`DHB_WAKE_CYC - 1)) begin
                  pw <= dhb_pkg::DHB_PW_RUN;
                  pw_cnt <= '0;
               end else begin
                  pw_cnt <= pw_cnt + 1'b1;
               end
            end
            dhb_pkg::DHB_PW_RUN: begin
               pw_cnt <= '0;
               if (!sleep_request_low) pw <= dhb_pkg::DHB_PW_ENTER;
            end
            dhb_pkg::DHB_PW_ENTER: begin
               if (pw_cnt == `DHB_CNT_W'(`DHB_SLEEP_CYC - 1)) begin
                  pw <= dhb_pkg::DHB_PW_SLEEP;
                  pw_cnt <= '0;
               end else begin
                  pw_cnt <= pw_cnt + 1'b1;
               end
            end
            default: pw <= dhb_pkg::DHB_PW_SLEEP;
         endcase
      end
   end
   // outputs keep running during the sleep entry delay
   assign run = (pw == dhb_pkg::DHB_PW_RUN) || (pw == dhb_pkg::DHB_PW_ENTER);

   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         internal_regulator_output <= 1'b0;
      end else begin
         internal_regulator_output <= (pw != dhb_pkg::DHB_PW_SLEEP);
      end
   end

   ////////////////////////////////////////////////////////////////
   // mode sampled once per wake, then frozen
   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         parallel_mode <= 1'b0;
      end else if (pw == dhb_pkg::DHB_PW_WAKE && pw_cnt == '0) begin
         parallel_mode <= bridge_a_ctrl_first_undriven
            & bridge_a_ctrl_second_undriven;
      end
   end

   ////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_bridge
         logic f;
         logic s;
         logic h;
         logic [1:0] df;
         logic [1:0] ds;
         // in parallel mode bridge b inputs steer both drivers
         assign f = (g == 0 && !parallel_mode) ? bridge_a_ctrl_first
            : bridge_b_ctrl_first;
         assign s = (g == 0 && !parallel_mode) ? bridge_a_ctrl_second
            : bridge_b_ctrl_second;
         assign h = (g == 0) && !parallel_mode
            && (bridge_a_ctrl_first_undriven || bridge_a_ctrl_second_undriven);
         dhb_bridge u_bridge (
            .aclk(aclk),
            .aresetn(rst_n),
            .run(run),
            .chop_en(chop_en),
            .thermal_shutdown(thermal_shutdown),
            .in_first(f),
            .in_second(s),
            .hold(h),
            .sense_trip(sense_trip[g]),
            .current_near_zero(current_near_zero[g]),
            .oc_high(oc_high_side[g]),
            .oc_low(oc_low_side[g]),
            .drive_first(df),
            .drive_second(ds),
            .oc_fault(oc_fault[g])
         );
         if (g == 0) begin : gen_a
            assign a_first = df;
            assign a_second = ds;
         end else begin : gen_b
            assign b_first = df;
            assign b_second = ds;
         end
      end
   endgenerate

   assign bridge_a_drive_first = a_first;
   assign bridge_a_drive_second = a_second;
   assign bridge_b_drive_first = b_first;
   assign bridge_b_drive_second = b_second;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_indicator_low <= 1'b0;
      end else begin
         fault_indicator_low <= ~(supply_undervoltage_lockout | thermal_shutdown
            | (|oc_fault));
      end
   end

   ////////////////////////////////////////////////////////////////
   // axi4-lite slave; the response waits for both address and data
   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready = !w_got && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         wd <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            wd <= s_axi_wdata;
         end
         if (aw_got && w_got) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[7:2] == `DHB_REG_CTRL >> 2
               || aw_addr[7:2] == `DHB_REG_STAT >> 2) && aw_addr[31:8] == '0
               ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chop_en <= 1'(`DHB_CTRL_RESET);
      end else if (aw_got && w_got && aw_addr == `DHB_REG_CTRL && s_axi_wstrb[0]) begin
         chop_en <= wd[`DHB_CTRL_CHOP_EN];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr)
            `DHB_REG_CTRL: s_axi_rdata <= {31'h0000_0000, chop_en};
            `DHB_REG_STAT: s_axi_rdata <= {24'h00_0000, pw, oc_fault, thermal_shutdown,
               supply_undervoltage_lockout, parallel_mode, ~fault_indicator_low};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // dhb_core
`default_nettype wire

// >>> src/dhb_params.svh
// How it works
// - input pair 00 coast 01 rev 10 fwd 11 brake
// - first bridge undriven input holds previous outputs outside parallel mode
// - parallel mode latched from undriven inputs at wake
// - mode changes only at next reset or wake
// - chop trip gives fixed 20 us off-time
// - 1.8 us blanking ignores comparator, minimum on-time
// - trip when sense exceeds reference over 6.6
// - off-time: first quarter fast, rest slow decay
// - fast decay reverses drive, stops near zero current
// - slow decay turns on both low sides
// - overcurrent over 2.8 us disables bridge, fault low
// - retry after 1.6 ms, then release fault
// - overcurrent handling separate per bridge
// - overcurrent from high and low side flags
// - overtemperature disables bridges until it clears
// - undervoltage resets sequencing, mode and bridges and holds fault low
// - sleep after delay: outputs off, regulator off
// - wake delay before outputs follow inputs
`ifndef DHB_PARAMS_SVH
`define DHB_PARAMS_SVH
`define DHB_CLK_NS 100
`define DHB_OFF_NS 20000
`define DHB_BLANK_NS 1800
`define DHB_DEG_NS 2800
`define DHB_RETRY_NS 1600000
`define DHB_SLEEP_NS 1000
`define DHB_WAKE_NS 1000
// least times round up, all counts at least one cycle
`define DHB_OFF_CYC ((`DHB_OFF_NS + `DHB_CLK_NS - 1) / `DHB_CLK_NS)
`define DHB_FAST_CYC ((`DHB_OFF_CYC + 3) / 4)
`define DHB_BLANK_CYC ((`DHB_BLANK_NS + `DHB_CLK_NS - 1) / `DHB_CLK_NS)
`define DHB_DEG_CYC ((`DHB_DEG_NS + `DHB_CLK_NS - 1) / `DHB_CLK_NS)
`define DHB_RETRY_CYC ((`DHB_RETRY_NS + `DHB_CLK_NS - 1) / `DHB_CLK_NS)
`define DHB_SLEEP_CYC ((`DHB_SLEEP_NS + `DHB_CLK_NS - 1) / `DHB_CLK_NS)
`define DHB_WAKE_CYC ((`DHB_WAKE_NS + `DHB_CLK_NS - 1) / `DHB_CLK_NS)
`define DHB_CNT_W 16
`define DHB_REG_CTRL 32'h0000_0000
`define DHB_REG_STAT 32'h0000_0004
`define DHB_CTRL_CHOP_EN 0
`define DHB_CTRL_RESET 32'h0000_0001
`endif

// >>> src/dhb_pkg.sv
package dhb_pkg;
   typedef enum logic [1:0] {
      DHB_DRV_OFF = 2'b00,
      DHB_DRV_LOW = 2'b01,
      DHB_DRV_HIGH = 2'b10
   } dhb_drv_t;
   typedef enum logic [2:0] {
      DHB_CH_DRIVE = 3'b000,
      DHB_CH_FAST = 3'b001,
      DHB_CH_SLOW = 3'b010,
      DHB_CH_OCP = 3'b011
   } dhb_chop_t;
   typedef enum logic [1:0] {
      DHB_PW_SLEEP = 2'b00,
      DHB_PW_WAKE = 2'b01,
      DHB_PW_RUN = 2'b10,
      DHB_PW_ENTER = 2'b11
   } dhb_pwr_t;
endpackage

// >>> src/dhb_bridge.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhb_params.svh"
// one h-bridge: truth table, chopping, decay, overcurrent
module dhb_bridge (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic chop_en,
   input wire logic thermal_shutdown,
   input wire logic in_first,
   input wire logic in_second,
   input wire logic hold,
   input wire logic sense_trip,
   input wire logic current_near_zero,
   input wire logic oc_high,
   input wire logic oc_low,
   output logic [1:0] drive_first,
   output logic [1:0] drive_second,
   output logic oc_fault
);
   dhb_pkg::dhb_chop_t st;
   logic [`DHB_CNT_W-1:0] cnt;
   logic [`DHB_CNT_W-1:0] oc_cnt;
   logic [1:0] pair;
   logic [1:0] held;
   logic fast_stop;
   logic [1:0] next_first;
   logic [1:0] next_second;
   wire logic oc_any = oc_high | oc_low;
   // held pair decides, so released lines cannot disturb chopping
   wire logic driving = pair[1] ^ pair[0];

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         held <= 2'b00;
      end else if (!hold) begin
         held <= {in_first, in_second};
      end
   end
   assign pair = hold ? held : {in_first, in_second};

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         st <= dhb_pkg::DHB_CH_DRIVE;
         cnt <= '0;
         fast_stop <= 1'b0;
      end else begin
         case (st)
            dhb_pkg::DHB_CH_DRIVE: begin
               if (!driving) begin
                  cnt <= '0;
               end else if (cnt < `DHB_CNT_W'(`DHB_BLANK_CYC)) begin
                  cnt <= cnt + 1'b1;
               end else if (chop_en && sense_trip) begin
                  st <= dhb_pkg::DHB_CH_FAST;
                  cnt <= '0;
                  fast_stop <= 1'b0;
               end
            end
            dhb_pkg::DHB_CH_FAST: begin
               if (current_near_zero) fast_stop <= 1'b1;
               cnt <= cnt + 1'b1;
               if (cnt == `DHB_CNT_W'(`DHB_FAST_CYC - 1)) st <= dhb_pkg::DHB_CH_SLOW;
            end
            dhb_pkg::DHB_CH_SLOW: begin
               if (cnt == `DHB_CNT_W'(`DHB_OFF_CYC - 1)) begin
                  st <= dhb_pkg::DHB_CH_DRIVE;
                  cnt <= '0;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: st <= dhb_pkg::DHB_CH_DRIVE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // retry counter runs to full period before release
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         oc_cnt <= '0;
         oc_fault <= 1'b0;
      end else if (oc_fault) begin
         if (oc_cnt == `DHB_CNT_W'(`DHB_RETRY_CYC - 1)) begin
            oc_fault <= 1'b0;
            oc_cnt <= '0;
         end else begin
            oc_cnt <= oc_cnt + 1'b1;
         end
      end else if (oc_any) begin
         if (oc_cnt == `DHB_CNT_W'(`DHB_DEG_CYC - 1)) begin
            oc_fault <= 1'b1;
            oc_cnt <= '0;
         end else begin
            oc_cnt <= oc_cnt + 1'b1;
         end
      end else begin
         oc_cnt <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_comb begin
      next_first = dhb_pkg::DHB_DRV_OFF;
      next_second = dhb_pkg::DHB_DRV_OFF;
      case (pair)
         2'b01: begin
            next_first = dhb_pkg::DHB_DRV_LOW;
            next_second = dhb_pkg::DHB_DRV_HIGH;
         end
         2'b10: begin
            next_first = dhb_pkg::DHB_DRV_HIGH;
            next_second = dhb_pkg::DHB_DRV_LOW;
         end
         2'b11: begin
            next_first = dhb_pkg::DHB_DRV_LOW;
            next_second = dhb_pkg::DHB_DRV_LOW;
         end
         default: ;
      endcase
      // reversed drive taken from the pair, not from next_first in place
      if (st == dhb_pkg::DHB_CH_FAST && driving) begin
         next_first = pair[0] ? dhb_pkg::DHB_DRV_HIGH : dhb_pkg::DHB_DRV_LOW;
         next_second = pair[0] ? dhb_pkg::DHB_DRV_LOW : dhb_pkg::DHB_DRV_HIGH;
         if (fast_stop) begin
            next_first = dhb_pkg::DHB_DRV_OFF;
            next_second = dhb_pkg::DHB_DRV_OFF;
         end
      end
      if (st == dhb_pkg::DHB_CH_SLOW && driving) begin
         next_first = dhb_pkg::DHB_DRV_LOW;
         next_second = dhb_pkg::DHB_DRV_LOW;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !run || oc_fault || thermal_shutdown) begin
         drive_first <= dhb_pkg::DHB_DRV_OFF;
         drive_second <= dhb_pkg::DHB_DRV_OFF;
      end else begin
         drive_first <= next_first;
         drive_second <= next_second;
      end
   end
endmodule // dhb_bridge
`default_nettype wire

// >>> tb/dhb_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dhb_core_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bridge_a_ctrl_first_undriven,
   input wire logic bridge_a_ctrl_second_undriven,
   input wire logic bridge_b_ctrl_first,
   input wire logic bridge_b_ctrl_second,
   input wire logic sleep_request_low,
   input wire logic supply_undervoltage_lockout,
   input wire logic thermal_shutdown,
   input wire logic [1:0] sense_trip,
   input wire logic [1:0] oc_high_side,
   input wire logic [1:0] oc_low_side,
   input wire logic [1:0] bridge_a_drive_first,
   input wire logic [1:0] bridge_a_drive_second,
   input wire logic [1:0] bridge_b_drive_first,
   input wire logic [1:0] bridge_b_drive_second,
   input wire logic internal_regulator_output,
   input wire logic fault_indicator_low,
   input wire logic parallel_mode
);
   logic [8:0] quiet;
   logic [5:0] ocb;
   logic [3:0] slp;
   wire [3:0] da = {bridge_a_drive_first, bridge_a_drive_second};
   wire [3:0] db = {bridge_b_drive_first, bridge_b_drive_second};
   wire off = {da, db} == 8'h00;
   wire run = sleep_request_low && !supply_undervoltage_lockout;
   // steady state: no trip, no fault, awake; long enough for any off-time to end
   wire calm = run && !thermal_shutdown && fault_indicator_low
      && {sense_trip, oc_high_side, oc_low_side} == 6'h00;
   function automatic logic [3:0] tt(input logic f, input logic s);
      case ({f, s})
         2'b01: return 4'h6;
         2'b10: return 4'h9;
         2'b11: return 4'h5;
         default: return 4'h0;
      endcase
   endfunction
   always_ff @(posedge aclk) begin
      if (!aresetn || !calm) quiet <= 9'h000;
      else if (quiet != 9'h1FF) quiet <= quiet + 9'h001;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !run || !(oc_high_side[1] || oc_low_side[1])) ocb <= 6'h00;
      else if (ocb != 6'h3F) ocb <= ocb + 6'h01;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || sleep_request_low) slp <= 4'h0;
      else if (slp != 4'hF) slp <= slp + 4'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_TRUTH_B:
      assert property (quiet > 9'd250 && calm
         |=> db == tt($past(bridge_b_ctrl_first), $past(bridge_b_ctrl_second)))
      else $error("bridge b drive does not follow its inputs");
   AST_HOLD_A:
      assert property (quiet > 9'd250 && calm && !parallel_mode
         && (bridge_a_ctrl_first_undriven || bridge_a_ctrl_second_undriven) |=> $stable(da))
      else $error("bridge a changed while an input is undriven");
   AST_PARALLEL:
      assert property (quiet > 9'd250 && calm && parallel_mode |=> da == db)
      else $error("bridge a does not mirror bridge b in parallel mode");
   AST_OC_TRIP:
      assert property (ocb == 6'd30 |-> db == 4'h0 && !fault_indicator_low)
      else $error("persistent overcurrent did not shut bridge b");
   AST_OC_RETRY:
      assert property (ocb == 6'd30 |-> ##200 !fault_indicator_low)
      else $error("fault released before retry period");
   AST_TSD:
      assert property (thermal_shutdown [*3] |-> off && !fault_indicator_low)
      else $error("overtemperature did not disable bridges");
   AST_SUPPLY_UNDERVOLTAGE_LOCKOUT:
      assert property (supply_undervoltage_lockout [*2]
         |-> off && !fault_indicator_low && !internal_regulator_output)
      else $error("undervoltage did not shut down");
   AST_SLEEP:
      assert property (slp == 4'd13 |-> off && !internal_regulator_output)
      else $error("sleep not entered after delay");
   AST_WAKE:
      assert property ($rose(sleep_request_low) && !internal_regulator_output |=> off [*8])
      else $error("outputs moved during wake delay");
   cover property (parallel_mode && quiet > 9'd250);
   cover property (ocb == 6'd30);
   cover property (slp == 4'd13);
endmodule // dhb_core_checker
bind dhb_core dhb_core_checker u_dhb_core_checker (.*);
`default_nettype wire

// >>> tb/dhb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dhb_host_model #(
   parameter int WAKE_WAIT = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] cmd_a,
   input wire logic [1:0] cmd_b,
   input wire logic hiz_a,
   input wire logic sleep_cmd,
   output logic bridge_a_ctrl_first,
   output logic bridge_a_ctrl_first_undriven,
   output logic bridge_a_ctrl_second,
   output logic bridge_a_ctrl_second_undriven,
   output logic bridge_b_ctrl_first,
   output logic bridge_b_ctrl_second,
   output logic sleep_request_low
);
   logic [4:0] wait_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_cnt <= 5'(WAKE_WAIT);
         sleep_request_low <= 1'b1;
         {bridge_a_ctrl_first_undriven, bridge_a_ctrl_second_undriven} <= 2'h0;
         {bridge_a_ctrl_first, bridge_a_ctrl_second} <= 2'h0;
         {bridge_b_ctrl_first, bridge_b_ctrl_second} <= 2'h0;
      end else begin
         sleep_request_low <= sleep_cmd;
         {bridge_a_ctrl_first_undriven, bridge_a_ctrl_second_undriven} <= {2{hiz_a}};
         if (sleep_cmd && !sleep_request_low) wait_cnt <= 5'(WAKE_WAIT);
         else if (wait_cnt != 5'h00) wait_cnt <= wait_cnt - 5'h01;
         // a released line carries no held value, so it toggles
         if (hiz_a) begin
            {bridge_a_ctrl_first, bridge_a_ctrl_second} <= ~{bridge_a_ctrl_first,
               bridge_a_ctrl_second};
         end else if (wait_cnt == 5'h00) begin
            {bridge_a_ctrl_first, bridge_a_ctrl_second} <= cmd_a;
         end
         if (wait_cnt == 5'h00) {bridge_b_ctrl_first, bridge_b_ctrl_second} <= cmd_b;
      end
   end
endmodule // dhb_host_model
`default_nettype wire

// >>> tb/dual_hbridge_control_fault_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhb_params.svh"
module dual_hbridge_control_fault_logic_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, hiz_a;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, sense_trip, current_near_zero, oc_high_side;
   logic [1:0] oc_low_side, cmd_a, cmd_b, rs;
   logic [1:0] bridge_a_drive_first, bridge_a_drive_second;
   logic [1:0] bridge_b_drive_first, bridge_b_drive_second;
   logic bridge_a_ctrl_first, bridge_a_ctrl_first_undriven, bridge_a_ctrl_second;
   logic bridge_a_ctrl_second_undriven, bridge_b_ctrl_first, bridge_b_ctrl_second;
   logic sleep_request_low, supply_undervoltage_lockout, thermal_shutdown, sleep_cmd;
   logic internal_regulator_output, fault_indicator_low, parallel_mode;
   int fails, checks;
   dhb_core u_dhb_core (.*);
   dhb_host_model u_dhb_host_model (.*);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [3:0] tt(input logic [1:0] p);
      case (p)
         2'h1: return 4'h6;
         2'h2: return 4'h9;
         2'h3: return 4'h5;
         default: return 4'h0;
      endcase
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkbr(input logic [1:0] pa, input logic [1:0] pb);
      chk("bridge_a", {4'h0, tt(pa)}, {4'h0, bridge_a_drive_first, bridge_a_drive_second});
      chk("bridge_b", {4'h0, tt(pb)}, {4'h0, bridge_b_drive_first, bridge_b_drive_second});
   endtask
   task automatic cf(input logic e);
      chk("fault", {7'h00, e}, {7'h00, fault_indicator_low});
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic end_sim;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      repeat (25000) @(posedge aclk);
      fails++;
      end_sim;
   end
   initial begin
      seed = 32'h0000_5A38;
      {fails, checks} = {32'h0, 32'h0};
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {3{32'h0}};
      s_axi_wstrb = 4'hF;
      {sense_trip, current_near_zero, oc_high_side, oc_low_side, cmd_a, cmd_b} = 12'h000;
      {supply_undervoltage_lockout, thermal_shutdown, hiz_a, sleep_cmd} = 4'h1;
      wt(6);
      aresetn <= 1'b1;
      wt(30);
      rdr(`DHB_REG_CTRL);
      chk("ctrl_reset", 8'h01, rd[7:0]);
      wr(`DHB_REG_CTRL, 32'h0000_0000);
      rdr(`DHB_REG_CTRL);
      chk("ctrl_rw", 8'h00, rd[7:0]);
      wr(`DHB_REG_CTRL, 32'h0000_0001);
      rdr(`DHB_REG_STAT);
      chk("stat_pw", {6'h00, dhb_pkg::DHB_PW_RUN}, {6'h00, rd[7:6]});
      wr(32'h0000_0010, 32'hFFFF_FFFF);
      chk("wr_slverr", 8'h02, {6'h00, rs});
      rdr(32'h0000_0010);
      chk("rd_slverr", 8'h02, {6'h00, rs});
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         cmd_a <= (i < 4) ? 2'(i) : seed[1:0];
         cmd_b <= (i < 4) ? 2'(3 - i) : seed[3:2];
         wt(4);
         chkbr(cmd_a, cmd_b);
      end
      {cmd_a, cmd_b} <= 4'hA;
      wt(4);
      hiz_a <= 1'b1;
      cmd_b <= 2'h1;
      wt(6);
      chkbr(2'h2, 2'h1);
      // wake with a undriven selects parallel mode
      sleep_cmd <= 1'b0;
      wt(15);
      chk("regulator", 8'h00, {7'h00, internal_regulator_output});
      chkbr(2'h0, 2'h0);
      sleep_cmd <= 1'b1;
      wt(6);
      chkbr(2'h0, 2'h0);
      wt(30);
      chk("parallel", 8'h01, {7'h00, parallel_mode});
      chkbr(2'h1, 2'h1);
      hiz_a <= 1'b0;
      wt(5);
      chk("parallel", 8'h01, {7'h00, parallel_mode});
      sleep_cmd <= 1'b0;
      wt(15);
      sleep_cmd <= 1'b1;
      wt(30);
      chk("parallel", 8'h00, {7'h00, parallel_mode});
      chkbr(2'h2, 2'h1);
      cmd_b <= 2'h2;
      wt(40);
      sense_trip <= 2'h2;
      wt(1);
      sense_trip <= 2'h0;
      wt(4);
      chkbr(2'h2, 2'h1);
      wt(95);
      chkbr(2'h2, 2'h3);
      wt(130);
      chkbr(2'h2, 2'h2);
      sense_trip <= 2'h2;
      wt(1);
      sense_trip <= 2'h0;
      current_near_zero <= 2'h2;
      wt(5);
      chkbr(2'h2, 2'h0);
      current_near_zero <= 2'h0;
      wt(260);
      // coast first, so the new drive starts a fresh blanking interval
      cmd_b <= 2'h0;
      wt(3);
      cmd_b <= 2'h1;
      wt(3);
      sense_trip <= 2'h2;
      wt(1);
      sense_trip <= 2'h0;
      wt(5);
      chkbr(2'h2, 2'h1);
      cmd_b <= 2'h2;
      wt(300);
      oc_low_side <= 2'h2;
      wt(10);
      oc_low_side <= 2'h0;
      wt(3);
      cf(1'b1);
      oc_high_side <= 2'h2;
      wt(40);
      cf(1'b0);
      chkbr(2'h2, 2'h0);
      oc_high_side <= 2'h0;
      oc_low_side <= 2'h1;
      wt(40);
      chkbr(2'h0, 2'h0);
      oc_low_side <= 2'h0;
      wt(1000);
      cf(1'b0);
      wt(14960);
      cf(1'b0);
      wt(140);
      cf(1'b1);
      chkbr(2'h2, 2'h2);
      thermal_shutdown <= 1'b1;
      wt(5);
      cf(1'b0);
      chkbr(2'h0, 2'h0);
      thermal_shutdown <= 1'b0;
      wt(30);
      cf(1'b1);
      chkbr(2'h2, 2'h2);
      supply_undervoltage_lockout <= 1'b1;
      wt(5);
      chk("supply_undervoltage_lockout", 8'h00, {6'h00, internal_regulator_output, fault_indicator_low});
      chkbr(2'h0, 2'h0);
      supply_undervoltage_lockout <= 1'b0;
      wt(40);
      cf(1'b1);
      chkbr(2'h2, 2'h2);
      end_sim;
   end
endmodule // dual_hbridge_control_fault_logic_tb_top
`default_nettype wire
